/* src/opd_prescaler_ctrl.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Upper nibble sets second prescaler ratio 3..11
// - Lower nibble sets first prescaler ratio 3..11
// - Upper code 1111 holds second prescaler reset
// - Lower code 1111 holds first prescaler reset
// - Writing 0x01 to 0x0005 applies pending settings
// - Hold cleared: prescalers down until feedback seen
// - Hold set: no wait for feedback detection
// - Combined bit powers down both prescalers
// - Bit 1 powers down second, resets set
// - Bit 0 powers down first, resets clear
// - Setting 0x0405 bit 0 starts calibration
module opd_prescaler_ctrl (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic [15:0] I_AXI_AWADDR,
    input wire logic I_AXI_AWVALID,
    output logic O_AXI_AWREADY,
    input wire logic [31:0] I_AXI_WDATA,
    input wire logic [3:0] I_AXI_WSTRB,
    input wire logic I_AXI_WVALID,
    output logic O_AXI_WREADY,
    output logic [1:0] O_AXI_BRESP,
    output logic O_AXI_BVALID,
    input wire logic I_AXI_BREADY,
    input wire logic [15:0] I_AXI_ARADDR,
    input wire logic I_AXI_ARVALID,
    output logic O_AXI_ARREADY,
    output logic [31:0] O_AXI_RDATA,
    output logic [1:0] O_AXI_RRESP,
    output logic O_AXI_RVALID,
    input wire logic I_AXI_RREADY,
    input wire logic I_FB_DETECT,
    input wire logic I_FULL_PD,
    output logic [3:0] O_FIRST_RATIO,
    output logic [3:0] O_SECOND_RATIO,
    output logic O_FIRST_RESET,
    output logic O_SECOND_RESET,
    output logic O_FIRST_PD,
    output logic O_SECOND_PD,
    output logic O_CAL_START,
    output logic O_CAL_RESET
);
    logic aw_ready_ff;
    logic w_ready_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [15:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic b_valid_ff;
    logic [1:0] b_resp_ff;
    logic ar_ready_ff;
    logic r_valid_ff;
    logic [31:0] r_data_ff;
    logic [1:0] r_resp_ff;

    logic [7:0] ratio_sh_ff;
    logic [7:0] power_sh_ff;
    logic [7:0] ratio_act_ff;
    logic [7:0] power_act_ff;
    logic [7:0] pll_ctrl_ff;
    logic io_update_ff;
    logic fb_meta_ff;
    logic fb_sync_ff;
    logic fb_seen_ff;
    logic [3:0] first_ratio_ff;
    logic [3:0] second_ratio_ff;
    logic first_reset_ff;
    logic second_reset_ff;
    logic first_pd_ff;
    logic second_pd_ff;
    logic cal_start_ff;
    logic cal_reset_ff;

    logic wr_fire;
    logic wr_lane0;
    logic [7:0] wr_byte;
    logic wr_mapped;
    logic [31:0] rd_data;
    logic rd_mapped;
    logic startup_block;
    logic [7:0] nxt_pll_ctrl;
    logic wr_ratio;
    logic wr_power;
    logic wr_strobe;
    logic wr_pll;

    function automatic logic [3:0] ratio_of(input logic [3:0] code);
        if (code < opd_pkg::CODE_MIN_SHIFT) begin
            ratio_of = opd_pkg::RATIO_MIN;
        end else if (code <= opd_pkg::CODE_MAX_VALID) begin
            ratio_of = 4'(code + opd_pkg::RATIO_OFFSET);
        end else begin
            ratio_of = opd_pkg::RATIO_MIN;
        end
    endfunction

    // Undefined codes above 1001 also park the divider in reset
    function automatic logic is_reset(input logic [3:0] code);
        is_reset = (code == opd_pkg::CODE_RESET) || (code > opd_pkg::CODE_MAX_VALID);
    endfunction

    assign wr_fire = aw_held_ff && w_held_ff && !b_valid_ff;
    assign wr_lane0 = w_strb_ff[0];
    assign wr_byte = w_data_ff[7:0];
    assign wr_ratio = wr_fire && wr_lane0 && (aw_addr_ff == opd_pkg::ADR_PRESCALER_RATIO);
    assign wr_power = wr_fire && wr_lane0 && (aw_addr_ff == opd_pkg::ADR_PRESCALER_POWER);
    assign wr_strobe = wr_fire && wr_lane0 && (aw_addr_ff == opd_pkg::ADR_IO_UPDATE);
    assign wr_pll = wr_fire && wr_lane0 && (aw_addr_ff == opd_pkg::ADR_PLL_CTRL);

    // Status word is read-only: a write to it is answered OKAY and dropped
    always_comb begin
        unique case (aw_addr_ff)
            opd_pkg::ADR_IO_UPDATE, opd_pkg::ADR_PLL_CTRL, opd_pkg::ADR_RESERVED_GAP: wr_mapped = 1'b1;
            opd_pkg::ADR_PRESCALER_RATIO, opd_pkg::ADR_PRESCALER_POWER: wr_mapped = 1'b1;
            opd_pkg::ADR_PRESCALER_STATUS: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end

    // Write address channel
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            aw_ready_ff <= 1'b0;
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 16'h0000;
        end else if (I_AXI_AWVALID && aw_ready_ff) begin
            aw_ready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            aw_addr_ff <= I_AXI_AWADDR;
        end else if (b_valid_ff && I_AXI_BREADY) begin
            aw_ready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
        end else if (!aw_held_ff) begin
            aw_ready_ff <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            w_ready_ff <= 1'b0;
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
        end else if (I_AXI_WVALID && w_ready_ff) begin
            w_ready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            w_data_ff <= I_AXI_WDATA;
            w_strb_ff <= I_AXI_WSTRB;
        end else if (b_valid_ff && I_AXI_BREADY) begin
            w_ready_ff <= 1'b1;
            w_held_ff <= 1'b0;
        end else if (!w_held_ff) begin
            w_ready_ff <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            b_valid_ff <= 1'b0;
            b_resp_ff <= opd_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            b_valid_ff <= 1'b1;
            b_resp_ff <= wr_mapped ? opd_pkg::RESP_OKAY : opd_pkg::RESP_SLVERR;
        end else if (b_valid_ff && I_AXI_BREADY) begin
            b_valid_ff <= 1'b0;
        end
    end

    // Shadow stage: ratio and power writes land here only
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            ratio_sh_ff <= opd_pkg::RATIO_RST;
            power_sh_ff <= opd_pkg::POWER_RST;
        end else begin
            if (wr_ratio) begin
                ratio_sh_ff <= wr_byte;
            end
            if (wr_power) begin
                power_sh_ff <= wr_byte & opd_pkg::POWER_WMASK;
            end
        end
    end

    // Transfer strobe only for the exact value 0x01
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            io_update_ff <= 1'b0;
        end else begin
            io_update_ff <= wr_strobe
                && (wr_byte == opd_pkg::IO_UPDATE_CODE);
        end
    end

    // Active copy steers the dividers
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            ratio_act_ff <= opd_pkg::RATIO_RST;
            power_act_ff <= opd_pkg::POWER_RST;
        end else if (io_update_ff) begin
            ratio_act_ff <= ratio_sh_ff;
            power_act_ff <= power_sh_ff;
        end
    end

    // Calibration control acts at once, edge triggered so a held 1 does not retrigger
    always_comb begin
        nxt_pll_ctrl = pll_ctrl_ff;
        if (wr_pll) begin
            nxt_pll_ctrl = (pll_ctrl_ff & ~opd_pkg::PLL_CTRL_WMASK) | (wr_byte & opd_pkg::PLL_CTRL_WMASK);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            pll_ctrl_ff <= opd_pkg::PLL_CTRL_RST;
            cal_start_ff <= 1'b0;
            cal_reset_ff <= 1'b0;
        end else begin
            pll_ctrl_ff <= nxt_pll_ctrl;
            cal_start_ff <= nxt_pll_ctrl[opd_pkg::PLL_CAL_START]
                && !pll_ctrl_ff[opd_pkg::PLL_CAL_START];
            cal_reset_ff <= nxt_pll_ctrl[opd_pkg::PLL_CAL_RESET]
                && !pll_ctrl_ff[opd_pkg::PLL_CAL_RESET];
        end
    end

    // Feedback detect comes from the analog side
    // Only the second stage is read: the first may be metastable
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            fb_meta_ff <= 1'b0;
            fb_sync_ff <= 1'b0;
        end else begin
            fb_meta_ff <= I_FB_DETECT;
            fb_sync_ff <= fb_meta_ff;
        end
    end

    // Full power-down re-arms the wait for feedback
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            fb_seen_ff <= 1'b0;
        end else if (I_FULL_PD) begin
            fb_seen_ff <= 1'b0;
        end else if (fb_sync_ff) begin
            fb_seen_ff <= 1'b1;
        end
    end

    assign startup_block = !power_act_ff[opd_pkg::PWR_STARTUP_HOLD] && !fb_seen_ff;

    // Divider outputs
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            first_ratio_ff <= ratio_of(opd_pkg::RATIO_RST[3:0]);
            second_ratio_ff <= ratio_of(opd_pkg::RATIO_RST[7:4]);
            first_reset_ff <= 1'b0;
            second_reset_ff <= 1'b0;
        end else begin
            first_ratio_ff <= ratio_of(ratio_act_ff[opd_pkg::RATIO_FIRST_LSB +: 4]);
            second_ratio_ff <= ratio_of(ratio_act_ff[opd_pkg::RATIO_SECOND_LSB +: 4]);
            first_reset_ff <= is_reset(ratio_act_ff[opd_pkg::RATIO_FIRST_LSB +: 4]);
            second_reset_ff <= is_reset(ratio_act_ff[opd_pkg::RATIO_SECOND_LSB +: 4]);
        end
    end

    // Reset state is powered down: the startup wait is in force
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            first_pd_ff <= 1'b1;
            second_pd_ff <= 1'b1;
        end else begin
            first_pd_ff <= power_act_ff[opd_pkg::PWR_BOTH_PD]
                || power_act_ff[opd_pkg::PWR_FIRST_PD]
                || startup_block;
            second_pd_ff <= power_act_ff[opd_pkg::PWR_BOTH_PD]
                || power_act_ff[opd_pkg::PWR_SECOND_PD]
                || startup_block;
        end
    end

    // Read decode
    always_comb begin
        rd_data = 32'h00000000;
        rd_mapped = 1'b1;
        unique case (I_AXI_ARADDR)
            opd_pkg::ADR_IO_UPDATE: rd_data = 32'h00000000;
            opd_pkg::ADR_PLL_CTRL: rd_data = {24'h000000, pll_ctrl_ff};
            opd_pkg::ADR_RESERVED_GAP: rd_data = 32'h00000000;
            opd_pkg::ADR_PRESCALER_RATIO: rd_data = {24'h000000, ratio_sh_ff};
            opd_pkg::ADR_PRESCALER_POWER: rd_data = {24'h000000, power_sh_ff};
            opd_pkg::ADR_PRESCALER_STATUS: begin
                rd_data = {8'h00, power_act_ff, ratio_act_ff, 1'b0, fb_seen_ff,
                    second_pd_ff, first_pd_ff, second_reset_ff, first_reset_ff, 2'h0};
            end
            default: rd_mapped = 1'b0;
        endcase
    end

    // Read channel
    // Zero wait: data is registered at the edge that takes the address
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            ar_ready_ff <= 1'b0;
            r_valid_ff <= 1'b0;
            r_data_ff <= 32'h00000000;
            r_resp_ff <= opd_pkg::RESP_OKAY;
        end else if (I_AXI_ARVALID && ar_ready_ff) begin
            ar_ready_ff <= 1'b0;
            r_valid_ff <= 1'b1;
            r_data_ff <= rd_data;
            r_resp_ff <= rd_mapped ? opd_pkg::RESP_OKAY : opd_pkg::RESP_SLVERR;
        end else if (r_valid_ff && I_AXI_RREADY) begin
            r_valid_ff <= 1'b0;
            ar_ready_ff <= 1'b1;
        end else if (!r_valid_ff) begin
            ar_ready_ff <= 1'b1;
        end
    end

    assign O_AXI_AWREADY = aw_ready_ff;
    assign O_AXI_WREADY = w_ready_ff;
    assign O_AXI_BVALID = b_valid_ff;
    assign O_AXI_BRESP = b_resp_ff;
    assign O_AXI_ARREADY = ar_ready_ff;
    assign O_AXI_RVALID = r_valid_ff;
    assign O_AXI_RDATA = r_data_ff;
    assign O_AXI_RRESP = r_resp_ff;
    assign O_FIRST_RATIO = first_ratio_ff;
    assign O_SECOND_RATIO = second_ratio_ff;
    assign O_FIRST_RESET = first_reset_ff;
    assign O_SECOND_RESET = second_reset_ff;
    assign O_FIRST_PD = first_pd_ff;
    assign O_SECOND_PD = second_pd_ff;
    assign O_CAL_START = cal_start_ff;
    assign O_CAL_RESET = cal_reset_ff;
endmodule

/* src/opd_pkg.sv */
package opd_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_IO_UPDATE = 16'h0005;
    localparam logic [15:0] IDX_PLL_CTRL = 16'h0405;
    localparam logic [15:0] IDX_RESERVED_GAP = 16'h0406;
    localparam logic [15:0] IDX_PRESCALER_RATIO = 16'h0407;
    localparam logic [15:0] IDX_PRESCALER_POWER = 16'h0408;
    localparam logic [15:0] IDX_PRESCALER_STATUS = 16'h0409;
    localparam int ADDR_W = 16;
    localparam logic [ADDR_W-1:0] ADR_IO_UPDATE = ADDR_W'(IDX_IO_UPDATE * 4);
    localparam logic [ADDR_W-1:0] ADR_PLL_CTRL = ADDR_W'(IDX_PLL_CTRL * 4);
    localparam logic [ADDR_W-1:0] ADR_RESERVED_GAP = ADDR_W'(IDX_RESERVED_GAP * 4);
    localparam logic [ADDR_W-1:0] ADR_PRESCALER_RATIO = ADDR_W'(IDX_PRESCALER_RATIO * 4);
    localparam logic [ADDR_W-1:0] ADR_PRESCALER_POWER = ADDR_W'(IDX_PRESCALER_POWER * 4);
    localparam logic [ADDR_W-1:0] ADR_PRESCALER_STATUS = ADDR_W'(IDX_PRESCALER_STATUS * 4);

    // Reset values and the update strobe code
    localparam logic [7:0] RATIO_RST = 8'h44;
    localparam logic [7:0] POWER_RST = 8'h02;
    localparam logic [7:0] PLL_CTRL_RST = 8'h20;
    localparam logic [7:0] IO_UPDATE_CODE = 8'h01;

    // Prescaler ratio fields
    localparam int RATIO_SECOND_LSB = 4;
    localparam int RATIO_FIRST_LSB = 0;
    localparam logic [3:0] CODE_RESET = 4'hF;
    localparam logic [3:0] CODE_MAX_VALID = 4'h9;
    localparam logic [3:0] CODE_MIN_SHIFT = 4'h2;
    localparam logic [3:0] RATIO_MIN = 4'h3;
    localparam logic [3:0] RATIO_OFFSET = 4'h2;

    // Prescaler power control fields
    localparam int PWR_STARTUP_HOLD = 4;
    localparam int PWR_BOTH_PD = 2;
    localparam int PWR_SECOND_PD = 1;
    localparam int PWR_FIRST_PD = 0;
    localparam logic [7:0] POWER_WMASK = 8'h17;

    // Analog PLL control fields
    localparam int PLL_CAL_START = 0;
    localparam int PLL_CAL_RESET = 1;
    localparam logic [7:0] PLL_CTRL_WMASK = 8'h0B;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* tb/opd_prescaler_ctrl_asserts.sv */
`timescale 1ns/100ps
module opd_ctrl_asserts (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_AXI_AWVALID,
    input wire logic O_AXI_AWREADY,
    input wire logic I_AXI_WVALID,
    input wire logic O_AXI_WREADY,
    input wire logic [1:0] O_AXI_BRESP,
    input wire logic O_AXI_BVALID,
    input wire logic I_AXI_BREADY,
    input wire logic I_AXI_ARVALID,
    input wire logic O_AXI_ARREADY,
    input wire logic [31:0] O_AXI_RDATA,
    input wire logic O_AXI_RVALID,
    input wire logic I_AXI_RREADY,
    input wire logic [3:0] O_FIRST_RATIO,
    input wire logic [3:0] O_SECOND_RATIO,
    input wire logic O_CAL_START
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    property p_first_range;
        O_FIRST_RATIO inside {[4'h3:4'hB]};
    endproperty
    a_first_range: assert property (p_first_range) else $error("first ratio out of range");
    property p_second_range;
        O_SECOND_RATIO inside {[4'h3:4'hB]};
    endproperty
    a_second_range: assert property (p_second_range) else $error("second ratio out of range");
    // Ratios move only two edges after a write completes
    property p_ratio_apply;
        $changed({O_FIRST_RATIO, O_SECOND_RATIO}) |-> $past(O_AXI_BVALID, 2) && !$past(O_AXI_BVALID, 3);
    endproperty
    a_ratio_apply: assert property (p_ratio_apply) else $error("ratio changed without strobe");
    property p_cal_pulse;
        O_CAL_START |-> (O_AXI_BVALID && !$past(O_AXI_BVALID)) ##1 !O_CAL_START;
    endproperty
    a_cal_pulse: assert property (p_cal_pulse) else $error("calibration pulse misplaced");
    property p_wr_answer;
        I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY |=> !O_AXI_AWREADY ##1 O_AXI_BVALID;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write response late");
    property p_b_hold;
        O_AXI_BVALID && !I_AXI_BREADY |=> O_AXI_BVALID && $stable(O_AXI_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_answer;
        I_AXI_ARVALID && O_AXI_ARREADY |=> O_AXI_RVALID && !O_AXI_ARREADY;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read data late");
    property p_r_hold;
        O_AXI_RVALID && !I_AXI_RREADY |=> O_AXI_RVALID && $stable(O_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule
bind opd_prescaler_ctrl opd_ctrl_asserts u_chk (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
    .I_AXI_AWVALID(I_AXI_AWVALID), .O_AXI_AWREADY(O_AXI_AWREADY), .I_AXI_WVALID(I_AXI_WVALID),
    .O_AXI_WREADY(O_AXI_WREADY), .O_AXI_BRESP(O_AXI_BRESP), .O_AXI_BVALID(O_AXI_BVALID),
    .I_AXI_BREADY(I_AXI_BREADY), .I_AXI_ARVALID(I_AXI_ARVALID), .O_AXI_ARREADY(O_AXI_ARREADY),
    .O_AXI_RDATA(O_AXI_RDATA), .O_AXI_RVALID(O_AXI_RVALID), .I_AXI_RREADY(I_AXI_RREADY),
    .O_FIRST_RATIO(O_FIRST_RATIO), .O_SECOND_RATIO(O_SECOND_RATIO), .O_CAL_START(O_CAL_START));

/* tb/output_prescaler_divider_control_bench.sv */
`timescale 1ns/100ps
module output_prescaler_divider_control_bench;
    logic clk = 1'b0, rst = 1'b1, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic fb = 1'b0, fpd = 1'b0, aw_r, w_r, b_v, ar_r, r_v, f_rst, s_rst, f_pd, s_pd, cal_s, cal_r;
    logic [15:0] aw_a = 16'h0000, ar_a = 16'h0000;
    logic [31:0] w_d = 32'h00000000, r_d, rd;
    logic [1:0] b_resp, r_resp, rsp;
    logic [3:0] f_rat, s_rat;
    logic [3:0] w_s = 4'hF;
    logic [7:0] pw [4] = '{8'h04, 8'h00, 8'h01, 8'h02};
    int n_fail = 0, check_count = 0, cal_n = 0, cal_rn = 0;
    opd_prescaler_ctrl dut (.I_CLK(clk), .I_SYS_RST(rst), .I_AXI_AWADDR(aw_a), .I_AXI_AWVALID(aw_v),
        .O_AXI_AWREADY(aw_r), .I_AXI_WDATA(w_d), .I_AXI_WSTRB(w_s), .I_AXI_WVALID(w_v), .O_AXI_WREADY(w_r),
        .O_AXI_BRESP(b_resp), .O_AXI_BVALID(b_v), .I_AXI_BREADY(b_r), .I_AXI_ARADDR(ar_a),
        .I_AXI_ARVALID(ar_v), .O_AXI_ARREADY(ar_r), .O_AXI_RDATA(r_d), .O_AXI_RRESP(r_resp),
        .O_AXI_RVALID(r_v), .I_AXI_RREADY(r_r), .I_FB_DETECT(fb), .I_FULL_PD(fpd), .O_FIRST_RATIO(f_rat),
        .O_SECOND_RATIO(s_rat), .O_FIRST_RESET(f_rst), .O_SECOND_RESET(s_rst), .O_FIRST_PD(f_pd),
        .O_SECOND_PD(s_pd), .O_CAL_START(cal_s), .O_CAL_RESET(cal_r));
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (cal_s === 1'b1) cal_n++;
        if (cal_r === 1'b1) cal_rn++;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Handshakes sampled at the falling edge, where ready is settled
    task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge clk);
        aw_a <= a;
        w_d <= {24'h000000, d};
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        while (!tb) begin
            @(negedge clk);
            ta = aw_v && aw_r;
            tw = w_v && w_r;
            tb = b_r && b_v;
            r = b_resp;
            @(posedge clk);
            if (ta) aw_v <= 1'b0;
            if (tw) w_v <= 1'b0;
            if (tb) b_r <= 1'b0;
        end
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        tr = 1'b0;
        @(posedge clk);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        while (!tr) begin
            @(negedge clk);
            ta = ar_v && ar_r;
            tr = r_r && r_v;
            d = r_d;
            r = r_resp;
            @(posedge clk);
            if (ta) ar_v <= 1'b0;
            if (tr) r_r <= 1'b0;
        end
    endtask
    task automatic apply(input logic [15:0] a, input logic [7:0] d);
        wr(a, d, rsp);
        wr(opd_pkg::ADR_IO_UPDATE, 8'h01, rsp);
        repeat (2) @(negedge clk);
    endtask
    task automatic exp_div(input logic [3:0] fr, input logic [3:0] sr, input logic fx, input logic sx);
        if (!fx) check("first ratio", 32'(f_rat), 32'(fr));
        if (!sx) check("second ratio", 32'(s_rat), 32'(sr));
        check("first reset", 32'(f_rst), 32'(fx));
        check("second reset", 32'(s_rst), 32'(sx));
    endtask
    task automatic exp_pd(input logic f, input logic s);
        check("first pd", 32'(f_pd), 32'(f));
        check("second pd", 32'(s_pd), 32'(s));
    endtask
    function automatic logic [3:0] rat(input logic [3:0] c);
        return (c < 4'h2) ? 4'h3 : c + 4'h2;
    endfunction
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        exp_div(4'h6, 4'h6, 1'b0, 1'b0);
        exp_pd(1'b1, 1'b1);
        rd_reg(opd_pkg::ADR_PRESCALER_RATIO, rd, rsp);
        check("ratio reg", rd, 32'h00000044);
        rd_reg(opd_pkg::ADR_PRESCALER_POWER, rd, rsp);
        check("power reg", rd, 32'h00000002);
        rd_reg(opd_pkg::ADR_RESERVED_GAP, rd, rsp);
        check("reserved reg", rd, 32'h00000000);
        rd_reg(16'h1000, rd, rsp);
        check("unmapped rresp", 32'(rsp), 32'(opd_pkg::RESP_SLVERR));
        wr(16'h1000, 8'h55, rsp);
        check("unmapped bresp", 32'(rsp), 32'(opd_pkg::RESP_SLVERR));
        @(posedge clk);
        fb <= 1'b1;
        repeat (6) @(negedge clk);
        exp_pd(1'b0, 1'b1);
        wr(opd_pkg::ADR_PRESCALER_RATIO, 8'h9F, rsp);
        rd_reg(opd_pkg::ADR_PRESCALER_RATIO, rd, rsp);
        check("ratio shadow", rd, 32'h0000009F);
        w_s <= 4'hE;
        wr(opd_pkg::ADR_PRESCALER_RATIO, 8'h11, rsp);
        w_s <= 4'hF;
        rd_reg(opd_pkg::ADR_PRESCALER_RATIO, rd, rsp);
        check("lane 0 off", rd, 32'h0000009F);
        // Wrong strobe value must leave dividers alone
        wr(opd_pkg::ADR_IO_UPDATE, 8'h02, rsp);
        repeat (2) @(negedge clk);
        exp_div(4'h6, 4'h6, 1'b0, 1'b0);
        apply(opd_pkg::ADR_IO_UPDATE, 8'h01);
        exp_div(4'h3, 4'hB, 1'b1, 1'b0);
        apply(opd_pkg::ADR_PRESCALER_RATIO, 8'hF2);
        exp_div(4'h4, 4'h3, 1'b0, 1'b1);
        for (int c = 0; c < 10; c++) begin
            apply(opd_pkg::ADR_PRESCALER_RATIO, 8'hFF);
            exp_div(4'h3, 4'h3, 1'b1, 1'b1);
            apply(opd_pkg::ADR_PRESCALER_RATIO, {4'(9 - c), 4'(c)});
            exp_div(rat(4'(c)), rat(4'(9 - c)), 1'b0, 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            apply(opd_pkg::ADR_PRESCALER_POWER, pw[i]);
            exp_pd(pw[i][2] | pw[i][0], pw[i][2] | pw[i][1]);
        end
        @(posedge clk);
        fpd <= 1'b1;
        repeat (4) @(negedge clk);
        exp_pd(1'b1, 1'b1);
        apply(opd_pkg::ADR_PRESCALER_POWER, 8'h10);
        exp_pd(1'b0, 1'b0);
        @(posedge clk);
        fpd <= 1'b0;
        rd_reg(opd_pkg::ADR_PLL_CTRL, rd, rsp);
        check("pll ctrl reset", rd, 32'h00000020);
        wr(opd_pkg::ADR_PLL_CTRL, 8'h21, rsp);
        wr(opd_pkg::ADR_PLL_CTRL, 8'h21, rsp);
        repeat (3) @(negedge clk);
        check("cal pulses", 32'(cal_n), 32'd1);
        wr(opd_pkg::ADR_PLL_CTRL, 8'h23, rsp);
        // Ratio applied through the update strobe before the calibration is started again
        apply(opd_pkg::ADR_PRESCALER_RATIO, 8'h33);
        wr(opd_pkg::ADR_PLL_CTRL, 8'h22, rsp);
        wr(opd_pkg::ADR_PLL_CTRL, 8'h23, rsp);
        repeat (3) @(negedge clk);
        exp_div(4'h5, 4'h5, 1'b0, 1'b0);
        check("cal pulses again", 32'(cal_n), 32'd2);
        check("cal reset pulses", 32'(cal_rn), 32'd1);
        rd_reg(opd_pkg::ADR_PLL_CTRL, rd, rsp);
        check("pll ctrl reg", rd, 32'h00000023);
        print_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict;
    end
endmodule
